// ===== logic/uart_lfc_consts.svh
// Offsets, reset values, clock rate and timing counts of the line format block.
// Assumes inclusion by bare name from the package; the top module uses the macros without including it.
`ifndef UART_LFC_CONSTS_SVH
`define UART_LFC_CONSTS_SVH
`define IDX_DATA 3'h0
`define IDX_DIV_HI 3'h1
`define IDX_ALT 3'h2
`define IDX_LFC 3'h3
`define IDX_LSTAT 3'h5
`define LFC_RESET 8'h00
`define DIV_RESET 16'h0001
`define ALT_RESET 8'h00
`define CLK_HZ 10000000
`define HALF_ONE 2'h1
`define HALF_TWO 2'h2
`define HALF_THREE 2'h3
`endif

// ===== logic/uart_lfc_pkg.sv
// Types shared by the line format block and its surroundings.
// Assumes the constants header is on the include path.
package uart_lfc_pkg;
  `include "uart_lfc_consts.svh"
  // Line format register fields, msb first.
  typedef struct packed {
    logic divisor_access_select;
    logic break_ctl;
    logic forced_parity;
    logic even_sel;
    logic parity_enable;
    logic stop_long;
    logic [1:0] word_len;
  } lfc_t;
  // Avalon-MM request group.
  typedef struct packed {
    logic [4:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } avm_req_t;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
endpackage : uart_lfc_pkg

// ===== logic/uart_line_control.sv
// One UART channel around its line format control register, reached over Avalon-MM.
// Assumes a 10 MHz clk_in, synchronous rx input and a master that holds requests.
module uart_line_control (
  input wire logic clk_in, // 10 MHz clock.
  input wire logic rst_in, // Synchronous reset, active high.
  input wire uart_lfc_pkg::avm_req_t avm_in, // Avalon-MM request.
  input wire logic serial_input_in, // Serial receive line.
  output logic [31:0] avm_readdata_out, // Avalon-MM read data.
  output logic avm_waitrequest_out, // Avalon-MM wait request.
  output logic serial_output_out // Serial transmit line.
);
  import uart_lfc_pkg::*;

  lfc_t lfc_q;
  logic [15:0] div_q;
  logic [7:0] alt_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic txd_q;
  // Two-entry transmit holding buffer.
  logic [7:0] buf_q [2];
  logic wptr_q, rptr_q;
  logic [1:0] cnt_q;
  // Transmitter.
  tx_state_t tx_q;
  logic [7:0] tsh_q;
  logic [2:0] tbit_q;
  logic [1:0] thalf_q;
  logic [15:0] tdiv_q;
  logic tpar_q;
  // Receiver and status.
  rx_state_t rx_q;
  logic [7:0] rsh_q, rdat_q;
  logic [2:0] rbit_q;
  logic [1:0] rhalf_q;
  logic [15:0] rdiv_q;
  logic rpar_q, rrdy_q, ovr_q, perr_q, ferr_q;

  // Bus decode; a request is taken at the edge where waitrequest is low.
  wire req = avm_in.read | avm_in.write;
  wire [2:0] idx = avm_in.address[4:2];
  wire dsel = lfc_q.divisor_access_select;
  wire hit_hold = avm_in.write & (idx == `IDX_DATA) & ~dsel;
  wire buf_in_ready = cnt_q != 2'h2;
  wire accept = req & wait_q & (~hit_hold | buf_in_ready);
  wire done = req & ~wait_q;
  wire wr = done & avm_in.write;
  wire rd = done & avm_in.read;
  wire [7:0] wd = avm_in.writedata[7:0];
  wire rd_data = rd & ~dsel & (idx == `IDX_DATA);
  wire rd_stat = rd & (idx == `IDX_LSTAT);

  // Buffer handshake: filled by bus writes, drained by an idle transmitter.
  wire buf_out_valid = cnt_q != 2'h0;
  wire buf_out_ready = tx_q == TX_IDLE;
  wire push = wr & hit_hold;
  wire pop = buf_out_valid & buf_out_ready;
  wire [1:0] cnt_d = 2'(cnt_q + {1'b0, push} - {1'b0, pop});
  wire hold_empty = cnt_q == 2'h0;
  wire all_empty = hold_empty & (tx_q == TX_IDLE);

  // Read mux; divisor select steers the shared offsets.
  wire [7:0] stat = {1'b0, all_empty, hold_empty, 1'b0, ferr_q, perr_q, ovr_q, rrdy_q};
  wire [7:0] rmux =
    (idx == `IDX_DATA) ? (dsel ? div_q[7:0] : rdat_q) :
    (idx == `IDX_DIV_HI && dsel) ? div_q[15:8] :
    (idx == `IDX_ALT && dsel) ? alt_q :
    (idx == `IDX_LFC) ? lfc_q :
    (idx == `IDX_LSTAT) ? stat : 8'h00;

  // Parity level for a word under the current format.
  function automatic logic par_bit(input lfc_t f, input logic [7:0] d);
    logic x;
    x = ^d;
    par_bit = f.forced_parity ? ~f.even_sel : (f.even_sel ? x : ~x);
  endfunction : par_bit

  // Half-bit ticks; a bit time is two ticks of the divisor count.
  wire ttick = tdiv_q == 16'h0000;
  wire rtick = rdiv_q == 16'h0000;
  wire [2:0] last_bit = 3'(3'h4 + {1'b0, lfc_q.word_len});
  wire [1:0] stop_halves = ~lfc_q.stop_long ? `HALF_ONE :
    (lfc_q.word_len == 2'h0) ? `HALF_TWO : `HALF_THREE;
  wire [7:0] tmask = 8'hff >> (3'h3 - {1'b0, lfc_q.word_len});
  wire tx_line = (tx_q == TX_START) ? 1'b0 : (tx_q == TX_DATA) ? tsh_q[0] :
    (tx_q == TX_PAR) ? tpar_q : 1'b1;
  wire rx_par_bad = lfc_q.parity_enable & (rpar_q != par_bit(lfc_q, rsh_q));

  // Register bus slave and control registers.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      lfc_q <= `LFC_RESET;
      div_q <= `DIV_RESET;
      alt_q <= `ALT_RESET;
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= ~accept;
      if (accept) begin
        rdata_q <= {24'h00_0000, rmux};
      end
      if (wr && idx == `IDX_LFC) begin
        lfc_q <= wd;
      end
      if (wr && dsel && idx == `IDX_DATA) begin
        div_q[7:0] <= wd;
      end
      if (wr && dsel && idx == `IDX_DIV_HI) begin
        div_q[15:8] <= wd;
      end
      if (wr && dsel && idx == `IDX_ALT) begin
        alt_q <= wd;
      end
    end
  end

  // Holding buffer storage and pointers.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wptr_q <= 1'b0;
      rptr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        buf_q[wptr_q] <= wd;
        wptr_q <= ~wptr_q;
      end
      if (pop) begin
        rptr_q <= ~rptr_q;
      end
      cnt_q <= cnt_d;
    end
  end

  // Transmitter; it runs whether or not break is set.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tx_q <= TX_IDLE;
      tsh_q <= 8'h00;
      tbit_q <= 3'h0;
      thalf_q <= 2'h0;
      tdiv_q <= 16'h0000;
      tpar_q <= 1'b0;
    end else begin
      tdiv_q <= (ttick || tx_q == TX_IDLE) ? 16'(div_q - 16'h0001) : 16'(tdiv_q - 16'h0001);
      if (pop) begin
        tx_q <= TX_START;
        tsh_q <= buf_q[rptr_q];
        tpar_q <= par_bit(lfc_q, buf_q[rptr_q] & tmask);
        tbit_q <= 3'h0;
        thalf_q <= 2'h1;
      end else if (ttick && tx_q != TX_IDLE) begin
        if (thalf_q != 2'h0) begin
          thalf_q <= 2'(thalf_q - 2'h1);
        end else begin
          thalf_q <= 2'h1;
          unique case (tx_q)
            TX_START: tx_q <= TX_DATA;
            TX_DATA: begin
              tsh_q <= tsh_q >> 1;
              tbit_q <= 3'(tbit_q + 3'h1);
              if (tbit_q == last_bit) begin
                tx_q <= lfc_q.parity_enable ? TX_PAR : TX_STOP;
                thalf_q <= lfc_q.parity_enable ? 2'h1 : stop_halves;
              end
            end
            TX_PAR: begin
              tx_q <= TX_STOP;
              thalf_q <= stop_halves;
            end
            TX_STOP: tx_q <= TX_IDLE;
            TX_IDLE: tx_q <= TX_IDLE;
          endcase
        end
      end
    end
  end

  // Serial output; break overrides the transmitter's line.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      txd_q <= 1'b1;
    end else begin
      txd_q <= lfc_q.break_ctl ? 1'b0 : tx_line;
    end
  end

  // Receiver; samples mid-bit and checks parity and stop.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rx_q <= RX_IDLE;
      rsh_q <= 8'h00;
      rdat_q <= 8'h00;
      rbit_q <= 3'h0;
      rhalf_q <= 2'h0;
      rdiv_q <= 16'h0000;
      rpar_q <= 1'b0;
      rrdy_q <= 1'b0;
      ovr_q <= 1'b0;
      perr_q <= 1'b0;
      ferr_q <= 1'b0;
    end else begin
      rdiv_q <= (rtick || rx_q == RX_IDLE) ? 16'(div_q - 16'h0001) : 16'(rdiv_q - 16'h0001);
      // Reads clear status; a new event in the same cycle wins.
      if (rd_data) begin
        rrdy_q <= 1'b0;
      end
      if (rd_stat) begin
        ovr_q <= 1'b0;
        perr_q <= 1'b0;
        ferr_q <= 1'b0;
      end
      if (rx_q == RX_IDLE) begin
        if (!serial_input_in) begin
          rx_q <= RX_START;
          rhalf_q <= 2'h0;
          rbit_q <= 3'h0;
          rsh_q <= 8'h00;
        end
      end else if (rtick) begin
        if (rhalf_q != 2'h0) begin
          rhalf_q <= 2'(rhalf_q - 2'h1);
        end else begin
          rhalf_q <= 2'h1;
          unique case (rx_q)
            RX_START: rx_q <= serial_input_in ? RX_IDLE : RX_DATA;
            RX_DATA: begin
              rsh_q[rbit_q] <= serial_input_in;
              rbit_q <= 3'(rbit_q + 3'h1);
              if (rbit_q == last_bit) begin
                rx_q <= lfc_q.parity_enable ? RX_PAR : RX_STOP;
              end
            end
            RX_PAR: begin
              rpar_q <= serial_input_in;
              rx_q <= RX_STOP;
            end
            RX_STOP: begin
              rx_q <= RX_IDLE;
              rdat_q <= rsh_q;
              rrdy_q <= 1'b1;
              ovr_q <= (ovr_q & ~rd_stat) | (rrdy_q & ~rd_data);
              ferr_q <= (ferr_q & ~rd_stat) | ~serial_input_in;
              perr_q <= (perr_q & ~rd_stat) | rx_par_bad;
            end
            RX_IDLE: rx_q <= RX_IDLE;
          endcase
        end
      end
    end
  end

  assign avm_readdata_out = rdata_q;
  assign avm_waitrequest_out = wait_q;
  assign serial_output_out = txd_q;

  // Checks on the behaviour above.
  sequence s_lfc_wr;
    wr && idx == `IDX_LFC;
  endsequence
  sequence s_break_on;
    lfc_q.break_ctl;
  endsequence

  property p_break_low;
    @(posedge clk_in) disable iff (rst_in) s_break_on |=> !serial_output_out;
  endproperty
  a_break_low: assert property (p_break_low) else $error("Break did not force spacing.");

  property p_break_tx_runs;
    @(posedge clk_in) disable iff (rst_in)
      s_break_on and pop |=> tx_q == TX_START;
  endproperty
  a_break_tx_runs: assert property (p_break_tx_runs) else $error("Transmitter stalled.");

  property p_break_release;
    @(posedge clk_in) disable iff (rst_in)
      $fell(lfc_q.break_ctl) && tx_q == TX_IDLE && !pop |-> !serial_output_out ##1 serial_output_out;
  endproperty
  a_break_release: assert property (p_break_release) else $error("Output not idle.");

  property p_div_lo;
    @(posedge clk_in) disable iff (rst_in)
      wr && dsel && idx == `IDX_DATA |=> div_q[7:0] == $past(wd) && cnt_q == $past(cnt_d);
  endproperty
  a_div_lo: assert property (p_div_lo) else $error("Divisor latch write missed.");

  property p_normal_hold;
    @(posedge clk_in) disable iff (rst_in)
      wr && !dsel && idx == `IDX_DATA |=> $stable(div_q) && cnt_q != 2'h0;
  endproperty
  a_normal_hold: assert property (p_normal_hold) else $error("Holding write went astray.");

  property p_no_parity;
    @(posedge clk_in) disable iff (rst_in)
      !lfc_q.parity_enable && tx_q == TX_DATA |=> tx_q != TX_PAR;
  endproperty
  a_no_parity: assert property (p_no_parity) else $error("Parity sent while disabled.");

  property p_forced_level;
    @(posedge clk_in) disable iff (rst_in)
      tx_q == TX_PAR && lfc_q.forced_parity && !lfc_q.break_ctl
      |=> serial_output_out == ~lfc_q.even_sel;
  endproperty
  a_forced_level: assert property (p_forced_level) else $error("Forced parity wrong.");

  property p_reset_clear;
    @(posedge clk_in) rst_in |=> lfc_q == `LFC_RESET && serial_output_out;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("Format not reset.");

  property p_readback;
    @(posedge clk_in) disable iff (rst_in)
      s_lfc_wr ##[1:2] (accept && avm_in.read && idx == `IDX_LFC)
      |=> avm_readdata_out[7:0] == lfc_q;
  endproperty
  a_readback: assert property (p_readback) else $error("Format readback differs.");
endmodule : uart_line_control

// ===== bench/uart_remote_model.sv
// Remote serial end: decodes device characters and sends characters to the device.
// Assumes a bit time of four clocks (divisor 2) and format fields set by the bench.
module uart_remote_model (
  input wire logic clk_in, // Bench clock.
  input wire logic line_in, // Device serial output.
  output logic line_out // Device serial input.
);
  timeunit 1ns;
  timeprecision 1ns;
  int nbits = 8;
  logic par_en = 1'b0;
  int cyc = 0;
  int start_q[$];
  logic [9:0] got_q[$];
  // Cycle stamp used to time each start bit.
  always @(posedge clk_in) cyc <= cyc + 1;
  // Samples each bit near its middle; a break shows up as a lost stop bit.
  initial begin : decode
    logic [9:0] w;
    line_out = 1'b1;
    forever begin
      @(posedge clk_in);
      if (line_in === 1'b0) begin
        start_q.push_back(cyc);
        w = '0;
        @(posedge clk_in);
        for (int i = 0; i <= nbits + par_en; i++) begin
          repeat (4) @(posedge clk_in);
          if (i < nbits) w[i] = line_in;
          else if (i == nbits && par_en) w[8] = line_in;
          else w[9] = line_in;
        end
        got_q.push_back(w);
        while (line_in !== 1'b1) @(posedge clk_in);
      end
    end
  end
  // Sends start, data lsb first, the given parity level and one stop bit.
  task automatic send_char(input logic [7:0] d, input logic p);
    line_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    for (int i = 0; i < nbits; i++) begin
      line_out <= d[i];
      repeat (4) @(posedge clk_in);
    end
    if (par_en) begin
      line_out <= p;
      repeat (4) @(posedge clk_in);
    end
    line_out <= 1'b1;
    repeat (4) @(posedge clk_in);
  endtask : send_char
endmodule : uart_remote_model

// ===== bench/tb_uart_line_control.sv
// Self-checking bench for the line format block, with a remote serial end.
// Assumes the register map and bus timing of the line format block.
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin error_cnt++; \
  $display("unexpected %s expected %h seen %h", nm, ex, gt); end end
module tb_uart_line_control;
  timeunit 1ns;
  timeprecision 1ns;
  import uart_lfc_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic serial_input_in, avm_waitrequest_out, serial_output_out, brk_on = 1'b0;
  logic [31:0] avm_readdata_out;
  avm_req_t avm_q = '0;
  int error_cnt = 0, cmp_count = 0, ones = 0, seed = 32'hf970_ada7;
  logic [7:0] rd, d;
  logic [9:0] exp_q[$];
  logic [7:0] fmts [9] = '{8'h03, 8'h33, 8'h25, 8'h0b, 8'h1b, 8'h2b, 8'h3b, 8'h1c, 8'h0e};
  uart_line_control u_dut (.clk_in(clk_in), .rst_in(rst_in), .avm_in(avm_q),
    .serial_input_in(serial_input_in), .avm_readdata_out(avm_readdata_out),
    .avm_waitrequest_out(avm_waitrequest_out), .serial_output_out(serial_output_out));
  uart_remote_model u_far (.clk_in(clk_in), .line_in(serial_output_out),
    .line_out(serial_input_in));
  // Clock of 100 ns period.
  initial forever #50 clk_in = ~clk_in;
  // Counts cycles in which the line is not spacing while break is on.
  always @(posedge clk_in) if (brk_on && serial_output_out !== 1'b0) ones <= ones + 1;
  // Expected parity level: forced level, else even or odd over the data bits.
  function automatic logic par_of(input logic [7:0] f, input logic [7:0] v);
    return f[5] ? ~f[4] : (f[4] ? ^v : ~^v);
  endfunction : par_of
  // One bus access; holds the request until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [2:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    avm_q <= '{address: {idx, 2'b00}, read: ~wr, write: wr, writedata: {24'h00_0000, wd}};
    do begin
      @(posedge clk_in);
      n++;
    end while (avm_waitrequest_out !== 1'b0 && n < 3000);
    rd = avm_readdata_out[7:0];
    if (n >= 3000) error_cnt++;
    avm_q <= '0;
    @(posedge clk_in);
  endtask : bus
  // Reads line status until the given bit is set, within a bounded count.
  task automatic poll(input int b);
    int n;
    n = 0;
    do begin
      bus(1'b0, 3'h5, 8'h00);
      n++;
    end while (rd[b] !== 1'b1 && n < 300);
  endtask : poll
  // Sends four characters in one format; the fourth write waits for buffer room.
  task automatic tx_chk(input logic [7:0] f);
    int nb, per, n, sp;
    logic [7:0] dd, m;
    logic [9:0] w, g;
    nb = 5 + f[1:0];
    m = 8'hff >> (8 - nb);
    bus(1'b1, 3'h3, f);
    u_far.nbits = nb;
    u_far.par_en = f[3];
    u_far.got_q.delete();
    u_far.start_q.delete();
    repeat (4) begin
      dd = $random(seed);
      bus(1'b1, 3'h0, dd);
      exp_q.push_back({1'b1, f[3] & par_of(f, dd & m), dd & m});
    end
    n = 0;
    while (u_far.got_q.size() < 4 && n < 3000) begin
      @(posedge clk_in);
      n++;
    end
    repeat (4) begin
      w = exp_q.pop_front();
      g = u_far.got_q.pop_front();
      `CHK("sent character", w, g)
    end
    per = 2 * (2 * (1 + nb + f[3]) + (f[2] ? (nb == 5 ? 3 : 4) : 2));
    sp = u_far.start_q[1] - u_far.start_q[0];
    `CHK("char spacing", 1'b1, sp inside {[per:per + 2]})
  endtask : tx_chk
  // Prints the counts and the verdict, then ends the run.
  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  // Watchdog against a hung handshake.
  initial begin
    repeat (40000) @(posedge clk_in);
    error_cnt++;
    give_verdict;
  end
  // Main sequence.
  initial begin : main
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    bus(1'b0, 3'h3, 8'h00);
    `CHK("format reset", 8'h00, rd)
    bus(1'b1, 3'h3, 8'h80);
    bus(1'b1, 3'h0, 8'h02);
    bus(1'b1, 3'h1, 8'h00);
    d = $random(seed);
    bus(1'b1, 3'h2, d);
    bus(1'b0, 3'h0, 8'h00);
    `CHK("divisor low", 8'h02, rd)
    bus(1'b0, 3'h2, 8'h00);
    `CHK("alternate function", d, rd)
    d = ($random(seed) & 8'hbf) | 8'h80;
    bus(1'b1, 3'h3, d);
    bus(1'b0, 3'h3, 8'h00);
    `CHK("format readback", d, rd)
    bus(1'b1, 3'h3, 8'h03);
    bus(1'b0, 3'h2, 8'h00);
    `CHK("index 2 normal set", 8'h00, rd)
    bus(1'b1, 3'h4, 8'h5a);
    bus(1'b0, 3'h4, 8'h00);
    `CHK("unmapped read", 8'h00, rd)
    foreach (fmts[i]) tx_chk(fmts[i]);
    // Good then bad parity from the far end, in eight-bit even format.
    bus(1'b1, 3'h3, 8'h1b);
    u_far.nbits = 8;
    u_far.par_en = 1'b1;
    for (int i = 0; i < 2; i++) begin
      d = $random(seed);
      u_far.send_char(d, par_of(8'h1b, d) ^ i[0]);
      repeat (4) @(posedge clk_in);
      bus(1'b0, 3'h5, 8'h00);
      `CHK("parity error flag", i[0], rd[2])
      bus(1'b0, 3'h0, 8'h00);
      `CHK("received data", d, rd)
    end
    // Pad, break after holding empty, a lost word, clear after all empty.
    bus(1'b1, 3'h3, 8'h03);
    bus(1'b1, 3'h0, 8'h00);
    poll(5);
    bus(1'b1, 3'h3, 8'h43);
    brk_on <= 1'b1;
    bus(1'b0, 3'h3, 8'h00);
    `CHK("break readback", 8'h43, rd)
    bus(1'b1, 3'h0, 8'ha5);
    poll(6);
    `CHK("all empty during break", 1'b1, rd[6])
    brk_on <= 1'b0;
    `CHK("line held low", 0, ones)
    bus(1'b1, 3'h3, 8'h03);
    @(posedge clk_in);
    `CHK("line after break", 1'b1, serial_output_out)
    repeat (60) @(posedge clk_in);
    tx_chk(8'h1b);
    give_verdict;
  end
endmodule : tb_uart_line_control
